/* hw/phy_cfg_pkg.sv */
// Behaviour
// - Decode registers 16-20 and 30; rest reserved
// - Reserved configuration bits written zero, read ignored
// - Bit 14 forces link pass; 13 kills transmitter
// - Bit 12 bypasses scrambling at 100 Mb/s
// - Bit 10 disables jabber correction at 10 Mb/s
// - Bit 9 enables heartbeat at 10 Mb/s
// - Bit 8 suppresses half-duplex echo at 10 Mb/s
// - Bit 7 extends carrier sense at 10 Mb/s; resets to one
// - Preamble bit sets data valid start at 10 Mb/s
// - Preamble always delivered at 100 Mb/s
// - Bit 1 enables alternate next-page mode
// - Alternate mode adds clears for page-received flag
package phy_cfg_pkg;
    localparam int DATA_W = 16; // Register width
    localparam int ADDR_W = 5; // Register address width
    // Register addresses
    localparam logic [4:0] ADDR_PORT_CFG = 5'h10;
    localparam logic [4:0] ADDR_SECOND_STATUS = 5'h11;
    localparam logic [4:0] ADDR_INT_ENABLE = 5'h12;
    localparam logic [4:0] ADDR_STATUS_CHANGE = 5'h13;
    localparam logic [4:0] ADDR_LED_CFG = 5'h14;
    localparam logic [4:0] ADDR_TX_CONTROL = 5'h1e;
    // Port configuration field positions
    localparam int BIT_FORCE_LINK = 14;
    localparam int BIT_TX_DISABLE = 13;
    localparam int BIT_SCR_BYPASS = 12;
    localparam int BIT_JABBER_DIS = 10;
    localparam int BIT_HEARTBEAT = 9;
    localparam int BIT_ECHO_DIS = 8;
    localparam int BIT_CRS_EXT = 7;
    localparam int BIT_PREAMBLE_EN = 5;
    localparam int BIT_ALT_NP = 1;
    // Reset value and mask of implemented configuration bits
    localparam logic [15:0] CFG_RESET = 16'h0080;
    localparam logic [15:0] CFG_WRITABLE = 16'h77a2;
    localparam logic [15:0] REG_RESET = 16'h0000;
    // Management frame layout
    localparam logic [5:0] PREAMBLE_LEN = 6'h20;
    localparam logic [4:0] HDR_LAST = 5'h0c;
    localparam logic [4:0] DATA_LAST = 5'h0f;
    localparam logic [1:0] OP_READ = 2'h2;
    localparam logic [1:0] OP_WRITE = 2'h1;
    localparam logic [4:0] PHY_ADDR_DEFAULT = 5'h01;
    // Management frame states
    typedef enum logic [1:0] {ST_PRE, ST_HDR, ST_TA, ST_DATA} mdio_state_t;
endpackage : phy_cfg_pkg

/* hw/pin_level_if.sv */
`timescale 1ns/1ps
`default_nettype none
// Settled level of one synchronised pin
interface pin_level_if;
    logic level; // Filtered pin level
    modport src (output level);
    modport dst (input level);
endinterface : pin_level_if
`default_nettype wire

/* hw/pin_sync3.sv */
`timescale 1ns/1ps
`default_nettype none
// Three-stage pin synchroniser; level moves once stages two and three agree
module pin_sync3 (
    input wire logic clk_sys_i,
    input wire logic sys_rst_i,
    input wire logic pin_i,
    pin_level_if.src sync
);
    logic s1_q; // Metastability catcher, read only by s2_q
    logic s2_q; // Second stage
    logic s3_q; // Third stage
    // Shift chain and agreement filter
    always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            s1_q <= 1'b0;
            s2_q <= 1'b0;
            s3_q <= 1'b0;
            sync.level <= 1'b0;
        end else begin
            s1_q <= pin_i;
            s2_q <= s1_q;
            s3_q <= s2_q;
            if (s2_q == s3_q) begin
                sync.level <= s3_q;
            end
        end
    end
endmodule : pin_sync3
`default_nettype wire

/* hw/phy_port_config_regs.sv */
`timescale 1ns/1ps
`default_nettype none
// Product-specific management registers reached over the serial management pins
module phy_port_config_regs
    import phy_cfg_pkg::*;
#(
    parameter logic [4:0] PHY_ADDR = phy_cfg_pkg::PHY_ADDR_DEFAULT // Own address on the bus
) (
    input wire logic clk_sys_i,
    input wire logic sys_rst_i,
    input wire logic mdc_i,
    input wire logic mdio_i,
    output logic mdio_o,
    output logic mdio_oe_n_o,
    input wire logic speed100_i,
    input wire logic full_duplex_i,
    input wire logic [phy_cfg_pkg::DATA_W-1:0] second_status_i,
    input wire logic [phy_cfg_pkg::DATA_W-1:0] status_change_i,
    input wire logic page_rx_event_i,
    input wire logic mr_page_rx_i,
    input wire logic page_rx_read_i,
    output logic force_link_pass_o,
    output logic tx_disable_o,
    output logic scrambler_bypass_o,
    output logic jabber_correct_disable_o,
    output logic heartbeat_enable_o,
    output logic twisted_pair_echo_disable_o,
    output logic carrier_sense_extend_o,
    output logic preamble_deliver_o,
    output logic alt_next_page_mode_o,
    output logic page_received_o,
    output logic status_change_read_o,
    output logic [phy_cfg_pkg::DATA_W-1:0] interrupt_enable_o,
    output logic [phy_cfg_pkg::DATA_W-1:0] led_config_o,
    output logic [phy_cfg_pkg::DATA_W-1:0] transmit_control_o
);
    import phy_cfg_pkg::*;

    pin_level_if mdc_sync (); // Settled clock pin
    pin_level_if mdio_sync (); // Settled data pin

    // Synchronise both management pins
    pin_sync3 u_mdc_sync (
        .clk_sys_i(clk_sys_i),
        .sys_rst_i(sys_rst_i),
        .pin_i(mdc_i),
        .sync(mdc_sync.src)
    );
    pin_sync3 u_mdio_sync (
        .clk_sys_i(clk_sys_i),
        .sys_rst_i(sys_rst_i),
        .pin_i(mdio_i),
        .sync(mdio_sync.src)
    );

    logic mdc_prev_q; // Last settled clock level
    mdio_state_t state_q; // Frame position
    logic [5:0] pre_cnt_q; // Run of ones seen, saturating
    logic [4:0] bit_cnt_q; // Bit index inside a field
    logic [12:0] hdr_q; // Start bit, opcode, addresses
    logic [15:0] shift_q; // Data shifter, both directions
    logic rd_q; // Frame is a read of this device
    logic wr_q; // Frame is a write to this device
    logic [15:0] cfg_q; // Port configuration
    logic [15:0] int_en_q; // Interrupt enable storage
    logic [15:0] led_q; // LED configuration storage
    logic [15:0] txc_q; // Transmit control storage

    // Frame decode
    wire mdc_rise = mdc_sync.level & ~mdc_prev_q;
    wire mdio_bit = mdio_sync.level;
    wire [12:0] hdr_next = {hdr_q[11:0], mdio_bit};
    wire hdr_ok = hdr_next[12] & (hdr_next[9:5] == PHY_ADDR);
    wire hdr_rd = hdr_ok & (hdr_next[11:10] == OP_READ);
    wire hdr_wr = hdr_ok & (hdr_next[11:10] == OP_WRITE);
    wire [4:0] reg_addr = hdr_q[4:0];
    wire [15:0] wr_data = {shift_q[14:0], mdio_bit};
    wire wr_fire = mdc_rise & (state_q == ST_DATA) & (bit_cnt_q == DATA_LAST) & wr_q;
    wire rd_load = mdc_rise & (state_q == ST_TA) & (bit_cnt_q == 5'd1) & rd_q;

    // Register select; reserved and unlisted addresses read zero
    wire sel_cfg = (reg_addr == ADDR_PORT_CFG);
    wire sel_st2 = (reg_addr == ADDR_SECOND_STATUS);
    wire sel_ien = (reg_addr == ADDR_INT_ENABLE);
    wire sel_chg = (reg_addr == ADDR_STATUS_CHANGE);
    wire sel_led = (reg_addr == ADDR_LED_CFG);
    wire sel_txc = (reg_addr == ADDR_TX_CONTROL);
    wire [15:0] rd_data = ({16{sel_cfg}} & cfg_q) | ({16{sel_st2}} & second_status_i)
        | ({16{sel_ien}} & int_en_q) | ({16{sel_chg}} & status_change_i)
        | ({16{sel_led}} & led_q) | ({16{sel_txc}} & txc_q);

    // Configuration side effects
    wire alt_np = cfg_q[BIT_ALT_NP];
    wire page_clr = page_rx_read_i | (alt_np & (~mr_page_rx_i | cfg_q[BIT_TX_DISABLE]));

    // Clock edge history
    always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            mdc_prev_q <= 1'b0;
        end else begin
            mdc_prev_q <= mdc_sync.level;
        end
    end

    // Management frame engine, advancing on each settled clock rise
    always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            state_q <= ST_PRE;
            pre_cnt_q <= 6'd0;
            bit_cnt_q <= 5'd0;
            hdr_q <= 13'h0000;
            shift_q <= REG_RESET;
            rd_q <= 1'b0;
            wr_q <= 1'b0;
            mdio_o <= 1'b1;
            mdio_oe_n_o <= 1'b1;
        end else if (mdc_rise) begin
            unique case (state_q)
                // Count preamble ones; a zero after enough of them starts a frame
                ST_PRE: begin
                    mdio_oe_n_o <= 1'b1;
                    bit_cnt_q <= 5'd0;
                    if (mdio_bit) begin
                        if (pre_cnt_q != PREAMBLE_LEN) begin
                            pre_cnt_q <= pre_cnt_q + 6'd1;
                        end
                    end else begin
                        pre_cnt_q <= 6'd0;
                        if (pre_cnt_q == PREAMBLE_LEN) begin
                            state_q <= ST_HDR;
                        end
                    end
                end
                // Collect start, opcode and both addresses
                ST_HDR: begin
                    hdr_q <= hdr_next;
                    bit_cnt_q <= bit_cnt_q + 5'd1;
                    if (bit_cnt_q == HDR_LAST) begin
                        bit_cnt_q <= 5'd0;
                        rd_q <= hdr_rd;
                        wr_q <= hdr_wr;
                        state_q <= (hdr_rd | hdr_wr) ? ST_TA : ST_PRE;
                    end
                end
                // Turnaround: drive zero for the second half on reads
                ST_TA: begin
                    bit_cnt_q <= bit_cnt_q + 5'd1;
                    if (bit_cnt_q == 5'd0) begin
                        mdio_o <= 1'b0;
                        mdio_oe_n_o <= ~rd_q;
                    end else begin
                        bit_cnt_q <= 5'd0;
                        state_q <= ST_DATA;
                        mdio_o <= rd_data[15];
                        shift_q <= {rd_data[14:0], 1'b0};
                    end
                end
                // Sixteen data bits, most significant first
                ST_DATA: begin
                    bit_cnt_q <= bit_cnt_q + 5'd1;
                    mdio_o <= shift_q[15];
                    shift_q <= rd_q ? {shift_q[14:0], 1'b0} : wr_data;
                    if (bit_cnt_q == DATA_LAST) begin
                        mdio_oe_n_o <= 1'b1;
                        mdio_o <= 1'b1;
                        state_q <= ST_PRE;
                    end
                end
            endcase
        end
    end

    // Writable registers; reserved configuration bits stay zero
    always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            cfg_q <= CFG_RESET;
            int_en_q <= REG_RESET;
            led_q <= REG_RESET;
            txc_q <= REG_RESET;
        end else if (wr_fire) begin
            if (sel_cfg) begin
                cfg_q <= wr_data & CFG_WRITABLE;
            end
            if (sel_ien) begin
                int_en_q <= wr_data;
            end
            if (sel_led) begin
                led_q <= wr_data;
            end
            if (sel_txc) begin
                txc_q <= wr_data;
            end
        end
    end

    // Control outputs; the speed-dependent ones gated by the present speed and duplex
    always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            force_link_pass_o <= 1'b0;
            tx_disable_o <= 1'b0;
            scrambler_bypass_o <= 1'b0;
            jabber_correct_disable_o <= 1'b0;
            heartbeat_enable_o <= 1'b0;
            twisted_pair_echo_disable_o <= 1'b0;
            carrier_sense_extend_o <= 1'b0;
            preamble_deliver_o <= 1'b0;
            alt_next_page_mode_o <= 1'b0;
            interrupt_enable_o <= REG_RESET;
            led_config_o <= REG_RESET;
            transmit_control_o <= REG_RESET;
        end else begin
            force_link_pass_o <= cfg_q[BIT_FORCE_LINK];
            tx_disable_o <= cfg_q[BIT_TX_DISABLE];
            scrambler_bypass_o <= speed100_i & cfg_q[BIT_SCR_BYPASS];
            jabber_correct_disable_o <= ~speed100_i & cfg_q[BIT_JABBER_DIS];
            heartbeat_enable_o <= ~speed100_i & cfg_q[BIT_HEARTBEAT];
            twisted_pair_echo_disable_o <= ~speed100_i & ~full_duplex_i & cfg_q[BIT_ECHO_DIS];
            carrier_sense_extend_o <= ~speed100_i & cfg_q[BIT_CRS_EXT];
            preamble_deliver_o <= speed100_i | cfg_q[BIT_PREAMBLE_EN];
            alt_next_page_mode_o <= alt_np;
            interrupt_enable_o <= int_en_q;
            led_config_o <= led_q;
            transmit_control_o <= txc_q;
        end
    end

    // Page-received flag; a new page wins over any clear
    always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            page_received_o <= 1'b0;
            status_change_read_o <= 1'b0;
        end else begin
            if (page_rx_event_i) begin
                page_received_o <= 1'b1;
            end else if (page_clr) begin
                page_received_o <= 1'b0;
            end
            status_change_read_o <= rd_load & sel_chg;
        end
    end

    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (sys_rst_i);

    chk_reserved_read_zero: assert property (rd_load & ~(sel_cfg | sel_st2 | sel_ien
        | sel_chg | sel_led | sel_txc) |=> !mdio_o)
        else $error("reserved address did not read zero");
    chk_reserved_cfg_bits: assert property ((cfg_q & ~CFG_WRITABLE) == 16'h0000)
        else $error("reserved configuration bit set");
    chk_force_link_follow: assert property (wr_fire & sel_cfg ##1 1'b1 ##1 1'b1
        |-> force_link_pass_o == $past(wr_data[BIT_FORCE_LINK], 2))
        else $error("force link output not following write");
    chk_scramble_bypass_gate: assert property (!speed100_i |=> !scrambler_bypass_o)
        else $error("scrambler bypass outside 100 Mb/s");
    chk_jabber_gate: assert property (speed100_i |=> !jabber_correct_disable_o)
        else $error("jabber disable outside 10 Mb/s");
    chk_heartbeat_gate: assert property (!cfg_q[BIT_HEARTBEAT] |=> !heartbeat_enable_o)
        else $error("heartbeat on while bit clear");
    chk_echo_half_duplex: assert property (full_duplex_i |=> !twisted_pair_echo_disable_o)
        else $error("echo suppression in full duplex");
    chk_crs_extend_10m: assert property (!speed100_i & cfg_q[BIT_CRS_EXT]
        |=> carrier_sense_extend_o)
        else $error("carrier extension missing");
    chk_preamble_always_100: assert property (speed100_i |=> preamble_deliver_o)
        else $error("preamble not delivered at 100 Mb/s");
    chk_preamble_10m_bit: assert property (!speed100_i |=> preamble_deliver_o
        == $past(cfg_q[BIT_PREAMBLE_EN]))
        else $error("preamble enable not honoured at 10 Mb/s");
    chk_alt_np_follow: assert property ($rose(alt_np) |=> alt_next_page_mode_o)
        else $error("alternate next-page mode not applied");
    chk_page_alt_clear: assert property (page_received_o & alt_np & !mr_page_rx_i
        & !page_rx_event_i |=> !page_received_o)
        else $error("page flag not cleared in alternate mode");
    chk_cfg_after_reset: assert property ($fell(sys_rst_i) |-> cfg_q == CFG_RESET)
        else $error("configuration reset value wrong");
endmodule : phy_port_config_regs
`default_nettype wire

/* tb/mgmt_master_model.sv */
`timescale 1ns/1ps
`default_nettype none
// Station management master that drives the management clock and data pin
module mgmt_master_model
    import phy_cfg_pkg::*;
(
    input wire logic clk_sys_i, // Paces each half of a management bit
    input wire logic mdio_i, // Resolved level of the data pin
    output logic mdc_o, // Management clock, held low between frames
    output logic drive_o, // High while this side drives the pin
    output logic mdio_o // Data put on the pin
);
    initial begin
        mdc_o = 1'b0;
        drive_o = 1'b0;
        mdio_o = 1'b1;
    end
    // One frame of 64 bits; data changes with the falling clock, the pin is sampled before each rise from bit 47 on
    task automatic frame(input logic [63:0] bits, input int n_drv, output logic [16:0] rd);
        rd = '0;
        for (int i = 0; i < 64; i++) begin
            @(negedge clk_sys_i);
            mdc_o = 1'b0;
            drive_o = (i < n_drv);
            mdio_o = bits[63-i];
            repeat (6) @(negedge clk_sys_i);
            if (i >= 47) begin
                rd = {rd[15:0], mdio_i};
            end
            mdc_o = 1'b1;
            repeat (5) @(negedge clk_sys_i);
        end
        // Release the pin and stop the clock until the next frame
        @(negedge clk_sys_i);
        mdc_o = 1'b0;
        drive_o = 1'b0;
        mdio_o = 1'b1;
        repeat (6) @(negedge clk_sys_i);
    endtask : frame
    // Write frame: full preamble, then start, opcode, addresses, turnaround and data
    task automatic write_reg(input logic [4:0] addr, input logic [15:0] data);
        logic [16:0] rd;
        logic [15:0] d;
        d = (addr == ADDR_PORT_CFG) ? (data & CFG_WRITABLE) : data;
        frame({32'hffff_ffff, 2'h1, OP_WRITE, PHY_ADDR_DEFAULT, addr, 2'h2, d}, 64, rd);
    endtask : write_reg
    // Read frame: pin released from the turnaround on; returns turnaround bit and data
    task automatic read_reg(input logic [4:0] addr, output logic [16:0] rd);
        frame({32'hffff_ffff, 2'h1, OP_READ, PHY_ADDR_DEFAULT, addr, 18'h3_ffff}, 46, rd);
    endtask : read_reg
endmodule : mgmt_master_model
`default_nettype wire

/* tb/test_phy_port_configuration_regs.sv */
`timescale 1ns/1ps
`default_nettype none
// Self-checking bench for the port configuration register bank
module test_phy_port_configuration_regs;
    import phy_cfg_pkg::*;
    logic clk_sys_i = 1'b0; // 25 MHz system clock
    logic sys_rst_i = 1'b1; // Reset held at start
    logic spd = 1'b0, fdx = 1'b0, ev = 1'b0, mr = 1'b0, prd = 1'b0; // Mode and page inputs
    logic [15:0] ss = 16'h0000, sc = 16'h0000; // Status words fed in
    wire logic mdc, m_drv, m_dat, d_dat, d_oe_n, pg, scrd, pin; // Pin and flag nets
    wire logic [8:0] ctl; // Control outputs, bit 8 forced link down to bit 0 alternate mode
    wire logic [15:0] ie, led, txc; // Register contents
    logic [16:0] rd;
    logic [15:0] d, cm;
    logic [4:0] a;
    int error_cnt = 0, n_checks = 0, sc_cnt = 0, seed;
    // Pull-up on the data pin when nobody drives it
    assign pin = !d_oe_n ? d_dat : (m_drv ? m_dat : 1'b1);
    always #20 clk_sys_i = ~clk_sys_i;
    // Count read strobes of the status change register
    always @(posedge clk_sys_i) begin
        if (scrd === 1'b1) sc_cnt++;
    end
    mgmt_master_model u_mgmt (.clk_sys_i(clk_sys_i), .mdio_i(pin), .mdc_o(mdc), .drive_o(m_drv),
        .mdio_o(m_dat));
    phy_port_config_regs u_dut (.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i), .mdc_i(mdc),
        .mdio_i(pin), .mdio_o(d_dat), .mdio_oe_n_o(d_oe_n), .speed100_i(spd), .full_duplex_i(fdx),
        .second_status_i(ss), .status_change_i(sc), .page_rx_event_i(ev), .mr_page_rx_i(mr),
        .page_rx_read_i(prd), .force_link_pass_o(ctl[8]), .tx_disable_o(ctl[7]),
        .scrambler_bypass_o(ctl[6]), .jabber_correct_disable_o(ctl[5]),
        .heartbeat_enable_o(ctl[4]), .twisted_pair_echo_disable_o(ctl[3]),
        .carrier_sense_extend_o(ctl[2]), .preamble_deliver_o(ctl[1]),
        .alt_next_page_mode_o(ctl[0]), .page_received_o(pg), .status_change_read_o(scrd),
        .interrupt_enable_o(ie), .led_config_o(led), .transmit_control_o(txc));
    // Expected control outputs from configuration, speed and duplex
    function automatic logic [8:0] exp_ctrl(logic [15:0] c, logic s, logic f);
        return {c[14], c[13], s & c[12], !s & c[10], !s & c[9], !s & !f & c[8], !s & c[7],
            s | c[5], c[1]};
    endfunction : exp_ctrl
    // Compare one value and count it
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask : check
    // Pulse one page input for a single cycle and let the flag settle
    task automatic pulse(ref logic s);
        s = 1'b1;
        @(negedge clk_sys_i);
        s = 1'b0;
        repeat (2) @(negedge clk_sys_i);
    endtask : pulse
    task automatic final_report();
        $display("checks %0d mismatches %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : final_report
    // Watchdog: about twice the expected run of some 29,000 cycles
    initial begin
        #2_400_000;
        error_cnt++;
        $display("[ERR] watchdog expected done seen hang");
        final_report();
    end
    initial begin
        seed = 32'ha16c_5860;
        repeat (4) @(negedge clk_sys_i);
        sys_rst_i = 1'b0;
        repeat (6) @(negedge clk_sys_i);
        // Reset state
        check("ctrl", exp_ctrl(CFG_RESET, 1'b0, 1'b0), ctl);
        check("vectors", 0, {ie, led} | txc);
        u_mgmt.read_reg(ADDR_PORT_CFG, rd);
        check("cfg read", {1'b0, CFG_RESET}, rd);
        $display("test reset done");
        // Writable registers write and read back
        ss = 16'($random(seed));
        sc = 16'($random(seed));
        for (int i = 0; i < 4; i++) begin
            a = (i == 0) ? ADDR_PORT_CFG : (i == 1) ? ADDR_INT_ENABLE :
                (i == 2) ? ADDR_LED_CFG : ADDR_TX_CONTROL;
            d = 16'($random(seed));
            u_mgmt.write_reg(a, d);
            u_mgmt.read_reg(a, rd);
            check("rw read", {1'b0, (i == 0) ? (d & CFG_WRITABLE) : d}, rd);
            if (i > 0) check("rw port", d, (i == 1) ? ie : (i == 2) ? led : txc);
        end
        // Read-only, reserved and unimplemented places ignore writes
        cm = ie;
        for (int i = 0; i < 7; i++) begin
            a = (i == 0) ? ADDR_SECOND_STATUS : (i == 1) ? ADDR_STATUS_CHANGE :
                (i == 2) ? 5'h15 : (i == 3) ? 5'h19 : (i == 4) ? 5'h1b : (i == 5) ? 5'h1f : 5'h05;
            u_mgmt.write_reg(a, 16'hffff);
            u_mgmt.read_reg(a, rd);
            check("ro read", {1'b0, (i == 0) ? ss : (i == 1) ? sc : 16'h0000}, rd);
        end
        check("int kept", cm, ie);
        check("sc strobes", 1, sc_cnt);
        $display("test register map done");
        // Configuration fields against speed and duplex
        for (int k = 0; k < 10; k++) begin
            d = (k == 0) ? 16'hffff : (k == 1) ? 16'h0000 : 16'($random(seed));
            cm = d & CFG_WRITABLE;
            u_mgmt.write_reg(ADDR_PORT_CFG, d);
            for (int m = 0; m < 4; m++) begin
                spd = m[1];
                fdx = m[0];
                repeat (3) @(negedge clk_sys_i);
                check("ctrl mode", exp_ctrl(cm, spd, fdx), ctl);
            end
        end
        u_mgmt.read_reg(ADDR_PORT_CFG, rd);
        check("cfg kept", {1'b0, cm}, rd);
        $display("test configuration done");
        // Page flag without and with the alternate mode
        u_mgmt.write_reg(ADDR_PORT_CFG, 16'h0000);
        pulse(ev);
        check("page set", 1, pg);
        // Alternate clear condition met without the alternate mode must leave the flag alone
        repeat (4) @(negedge clk_sys_i);
        check("page held", 1, pg);
        ev = 1'b1;
        prd = 1'b1;
        @(negedge clk_sys_i);
        ev = 1'b0;
        prd = 1'b0;
        repeat (2) @(negedge clk_sys_i);
        check("page set wins", 1, pg);
        pulse(prd);
        check("page read clr", 0, pg);
        u_mgmt.write_reg(ADDR_PORT_CFG, 16'h0002);
        mr = 1'b1;
        pulse(ev);
        check("page alt set", 1, pg);
        mr = 1'b0;
        repeat (2) @(negedge clk_sys_i);
        check("page cond clr", 0, pg);
        mr = 1'b1;
        pulse(ev);
        u_mgmt.write_reg(ADDR_PORT_CFG, 16'h2002);
        check("page txdis clr", 0, pg);
        $display("test page flag done");
        final_report();
    end
endmodule : test_phy_port_configuration_regs
`default_nettype wire
